// File: logic/ccu_pkg.sv
// constants and types for the capture/compare unit
// Summary of operation
// - capture copies full timer count to value
// - mode picks falling, rising, 4th, 16th, any edge
// - capture sets flag; software clears it
// - newer capture overwrites held value
// - source select field picks capture input
// - detector watches pin even when driven
// - prescaler cleared when off or not capturing
// - direct prescaler change keeps count
// - timer holds in sleep unless external clock
// - compare value against timer on each timer tick
// - match does toggle, set, clear or pulse
// - every compare match raises flag
// - only modes 0001 and 1011 clear timer
// - zero control write forces output latch low
// - optional open-drain pin drive
// - several units share one timer
// - value read as two byte halves
// - compare output routed internally
package ccu_pkg;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_CAPSEL = 4'h4;
  localparam logic [3:0] ADR_VAL_LO = 4'h8;
  localparam logic [3:0] ADR_VAL_HI = 4'hc;
  localparam int CTRL_EN = 7;
  localparam int CTRL_OD = 6;
  localparam int CTRL_FLAG = 5;
  localparam int MODE_LSB = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] CAPSEL_RST = 2'h0;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [3:0] PS_RST = 4'h0;
  localparam logic [3:0] M_TOG_CLR = 4'h1;
  localparam logic [3:0] M_TOG = 4'h2;
  localparam logic [3:0] M_CAP_ANY = 4'h3;
  localparam logic [3:0] M_CAP_FALL = 4'h4;
  localparam logic [3:0] M_CAP_RISE = 4'h5;
  localparam logic [3:0] M_CAP_R4 = 4'h6;
  localparam logic [3:0] M_CAP_R16 = 4'h7;
  localparam logic [3:0] M_SET = 4'h8;
  localparam logic [3:0] M_CLR = 4'h9;
  localparam logic [3:0] M_PULSE = 4'ha;
  localparam logic [3:0] M_PULSE_CLR = 4'hb;
  localparam logic [3:0] PS_MAX4 = 4'h3;
  localparam logic [3:0] PS_MAX16 = 4'hf;
endpackage

// File: logic/ccu_top.sv
// capture/compare unit with classic wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module ccu_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // shared timer
  input wire logic [15:0] timer_i,
  input wire logic timer_tick_i,
  output logic timer_clr_o,
  // pin and capture sources
  input wire logic [3:0] cap_src_i,
  output logic pin_o,
  output logic pin_oe_o,
  // internal routing and flag
  output logic cmp_out_o,
  output logic irq_flag_o
);
  // register map, low byte of each word:
  //   0x0 control: 7 enable, 6 open drain, 5 flag, 3:0 mode
  //   0x4 source select: 1:0 picks the capture input
  //   0x8 value low byte, 0xc value high byte
  // the two value bytes are not read at once: a capture in between
  // mixes two events, so software reads twice or stops the unit
  logic [7:0] ctrl_r;
  logic [1:0] capsel_r;
  logic [15:0] val_r;
  logic flag_r;
  logic [3:0] ps_r;
  logic out_r;
  logic pulse_r;
  logic [3:0] src_s2_r;
  logic cap_d_r;
  logic [31:0] dat_r;
  logic ack_r;
  logic clr_r;
  logic pin_r;
  logic pin_oe_r;
  logic cmp_r;

  logic [3:0] mode;
  logic en;
  logic is_cap;
  logic is_cmp;
  logic cap_lvl;
  logic rise;
  logic fall;
  logic ps_hit;
  logic cap_ev;
  logic match;
  logic wr;
  logic rd;
  logic flag_clr_wr;
  logic ctrl_zero_wr;
  logic [3:0] ps_nxt;
  logic clr_mode;
  logic sel_ctrl;
  logic sel_capsel;
  logic sel_lo;
  logic sel_hi;
  logic pin_nxt;
  logic pin_oe_nxt;
  logic [31:0] dat_nxt;

  assign mode = ctrl_r[ccu_pkg::MODE_LSB +: 4];
  assign en = ctrl_r[ccu_pkg::CTRL_EN];
  // mode classes; codes 0 and c to f are idle, neither capture nor compare
  always_comb begin
    is_cap = 1'b0;
    is_cmp = 1'b0;
    clr_mode = 1'b0;
    case (mode)
      ccu_pkg::M_CAP_ANY,
      ccu_pkg::M_CAP_FALL,
      ccu_pkg::M_CAP_RISE,
      ccu_pkg::M_CAP_R4,
      ccu_pkg::M_CAP_R16: begin
        is_cap = 1'b1;
      end
      ccu_pkg::M_TOG,
      ccu_pkg::M_SET,
      ccu_pkg::M_CLR,
      ccu_pkg::M_PULSE: begin
        is_cmp = 1'b1;
      end
      // only these two codes clear the shared timer on a match
      ccu_pkg::M_TOG_CLR,
      ccu_pkg::M_PULSE_CLR: begin
        is_cmp = 1'b1;
        clr_mode = 1'b1;
      end
      default: begin
        is_cap = 1'b0;
        is_cmp = 1'b0;
        clr_mode = 1'b0;
      end
    endcase
  end
  assign wr = cyc_i && stb_i && we_i && !ack_r;
  assign rd = cyc_i && stb_i && !we_i && !ack_r;

  // each source passes two flops; bit 0 carries the pin level even when
  // the unit drives it, so a port write can start a capture
  for (genvar g = 0; g < 4; g++) begin : g_sync
    logic s1_r;
    logic s2_r;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
      end else if (ce_i) begin
        s1_r <= cap_src_i[g];
        s2_r <= s1_r;
      end
    end
    assign src_s2_r[g] = s2_r;
  end

  // previous detector level; idles low, so the rise seen just after
  // reset falls while the unit is still off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_d_r <= 1'b0;
    end else if (ce_i) begin
      cap_d_r <= cap_lvl;
    end
  end

  assign cap_lvl = src_s2_r[capsel_r];
  assign rise = cap_lvl && !cap_d_r;
  assign fall = !cap_lvl && cap_d_r;

  // event selection by mode
  always_comb begin
    ps_hit = 1'b0;
    cap_ev = 1'b0;
    ps_nxt = ps_r;
    if (en && is_cap) begin
      case (mode)
        ccu_pkg::M_CAP_ANY: begin
          cap_ev = rise || fall;
        end
        ccu_pkg::M_CAP_FALL: begin
          cap_ev = fall;
        end
        ccu_pkg::M_CAP_RISE: begin
          cap_ev = rise;
        end
        ccu_pkg::M_CAP_R4: begin
          ps_hit = rise && (ps_r[1:0] == ccu_pkg::PS_MAX4[1:0]);
          cap_ev = ps_hit;
        end
        ccu_pkg::M_CAP_R16: begin
          ps_hit = rise && (ps_r == ccu_pkg::PS_MAX16);
          cap_ev = ps_hit;
        end
        default: cap_ev = 1'b0;
      endcase
      // count keeps running across prescale changes
      if (rise && (mode == ccu_pkg::M_CAP_R4 ||
                   mode == ccu_pkg::M_CAP_R16)) begin
        ps_nxt = ps_hit ? ccu_pkg::PS_RST : ps_r + 4'h1;
      end
    end else begin
      ps_nxt = ccu_pkg::PS_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_r <= ccu_pkg::PS_RST;
    end else if (ce_i) begin
      ps_r <= ps_nxt;
    end
  end

  // timer shared by units; a stalled timer sends no tick, so a frozen
  // count never rematches and compare waits through sleep
  assign match = en && is_cmp && timer_tick_i &&
                 (timer_i == val_r);

  assign sel_ctrl = wr && sel_i[0] && (adr_i == ccu_pkg::ADR_CTRL);
  assign sel_capsel = wr && sel_i[0] && (adr_i == ccu_pkg::ADR_CAPSEL);
  assign sel_lo = wr && sel_i[0] && (adr_i == ccu_pkg::ADR_VAL_LO);
  assign sel_hi = wr && sel_i[0] && (adr_i == ccu_pkg::ADR_VAL_HI);
  // flag bit written as zero clears it, one leaves it
  assign flag_clr_wr = sel_ctrl && !dat_i[ccu_pkg::CTRL_FLAG];
  assign ctrl_zero_wr = sel_ctrl && (dat_i[7:0] == 8'h00);

  // control and source select registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= ccu_pkg::CTRL_RST;
      capsel_r <= ccu_pkg::CAPSEL_RST;
    end else if (ce_i) begin
      if (sel_ctrl) begin
        ctrl_r <= {dat_i[7:6], 1'b0, dat_i[4:0]};
      end
      if (sel_capsel) begin
        capsel_r <= dat_i[1:0];
      end
    end
  end

  // value register: capture overwrites, halves writable by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      val_r <= ccu_pkg::VAL_RST;
    end else if (ce_i) begin
      if (cap_ev) begin
        val_r <= timer_i;
      end else begin
        if (sel_lo) begin
          val_r[7:0] <= dat_i[7:0];
        end
        if (sel_hi) begin
          val_r[15:8] <= dat_i[7:0];
        end
      end
    end
  end

  // flag: set wins over software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else if (ce_i) begin
      if (cap_ev || match) begin
        flag_r <= 1'b1;
      end else if (flag_clr_wr) begin
        flag_r <= 1'b0;
      end
    end
  end

  // compare output latch and pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r <= 1'b0;
      pulse_r <= 1'b0;
    end else if (ce_i) begin
      if (ctrl_zero_wr) begin
        out_r <= 1'b0;
        pulse_r <= 1'b0;
      end else if (match) begin
        case (mode)
          ccu_pkg::M_TOG_CLR: out_r <= !out_r;
          ccu_pkg::M_TOG: out_r <= !out_r;
          ccu_pkg::M_SET: begin
            out_r <= 1'b1;
          end
          ccu_pkg::M_CLR: begin
            out_r <= 1'b0;
          end
          ccu_pkg::M_PULSE, ccu_pkg::M_PULSE_CLR: begin
            out_r <= 1'b1;
            pulse_r <= 1'b1;
          end
          default: out_r <= out_r;
        endcase
      end else if (pulse_r && timer_tick_i) begin
        out_r <= 1'b0;
        pulse_r <= 1'b0;
      end
    end
  end

  // pin drive; open drain only pulls low and releases for high
  always_comb begin
    pin_nxt = out_r;
    pin_oe_nxt = en && is_cmp;
    if (ctrl_r[ccu_pkg::CTRL_OD]) begin
      pin_nxt = 1'b0;
      pin_oe_nxt = en && is_cmp && !out_r;
    end
  end

  // output flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clr_r <= 1'b0;
      pin_r <= 1'b0;
      pin_oe_r <= 1'b0;
      cmp_r <= 1'b0;
    end else if (ce_i) begin
      clr_r <= match && clr_mode;
      cmp_r <= out_r;
      pin_r <= pin_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  // read mux; unmapped offsets read zero and are still answered
  always_comb begin
    dat_nxt = 32'h0000_0000;
    case (adr_i)
      ccu_pkg::ADR_CTRL: begin
        dat_nxt[7:0] = {ctrl_r[7:6], flag_r, ctrl_r[4:0]};
      end
      ccu_pkg::ADR_CAPSEL: begin
        dat_nxt[1:0] = capsel_r;
      end
      ccu_pkg::ADR_VAL_LO: begin
        dat_nxt[7:0] = val_r[7:0];
      end
      ccu_pkg::ADR_VAL_HI: begin
        dat_nxt[7:0] = val_r[15:8];
      end
      default: begin
        dat_nxt = 32'h0000_0000;
      end
    endcase
  end

  // wishbone: ack one cycle after the take, then dropped for a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else if (ce_i) begin
      ack_r <= cyc_i && stb_i && !ack_r;
    end
  end

  // read data holds until the next read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (ce_i && rd) begin
      dat_r <= dat_nxt;
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign timer_clr_o = clr_r;
  assign pin_o = pin_r;
  assign pin_oe_o = pin_oe_r;
  assign cmp_out_o = cmp_r;
  assign irq_flag_o = flag_r;
endmodule // ccu_top
`default_nettype wire

// File: test/ccu_properties.sv
// port-level checks for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module ccu_properties (
  // clock, reset and bus
  input wire logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o,
  input wire logic [3:0] adr_i, sel_i,
  input wire logic [31:0] dat_i,
  // timer and outputs
  input wire logic [15:0] timer_i,
  input wire logic timer_tick_i, timer_clr_o, pin_o, cmp_out_o, irq_flag_o
);
  logic [7:0] c_s;
  logic [15:0] v_s;
  logic [3:0] m;
  logic tk, wr, hit;
  assign tk = cyc_i && stb_i && !ack_o && ce_i;
  assign wr = tk && we_i && sel_i[0];
  assign m = c_s[3:0];
  // shadow of software writes only; captures are not tracked
  assign hit = c_s[7] && (m inside {[4'h8:4'hb], 4'h1, 4'h2}) && ce_i
    && timer_tick_i && timer_i == v_s;
  always_ff @(posedge clk_i)
    if (rst_i) c_s <= 8'h00;
    else if (wr && adr_i == ccu_pkg::ADR_CTRL) c_s <= dat_i[7:0];
  always_ff @(posedge clk_i)
    if (rst_i) v_s <= 16'h0000;
    else if (wr && adr_i == ccu_pkg::ADR_VAL_LO) v_s[7:0] <= dat_i[7:0];
    else if (wr && adr_i == ccu_pkg::ADR_VAL_HI) v_s[15:8] <= dat_i[7:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_reply_a: assert property (tk |=> ack_o)
    else $error("request not answered");
  match_flag_a:
    assert property (hit |=> irq_flag_o) else $error("no flag on match");
  flag_hold_a:
    assert property ($fell(irq_flag_o) |-> ack_o && we_i)
    else $error("flag cleared without a write");
  set_out_a:
    assert property (hit && m == ccu_pkg::M_SET |-> ##2 cmp_out_o)
    else $error("set mode left output low");
  clr_out_a:
    assert property (hit && m == ccu_pkg::M_CLR |-> ##2 !cmp_out_o)
    else $error("clear mode left output high");
  toggle_out_a:
    assert property (hit && m inside {4'h1, 4'h2}
      |-> ##2 cmp_out_o != $past(cmp_out_o, 2))
    else $error("toggle mode did not toggle");
  timer_clear_a:
    assert property (hit
      |-> ##1 timer_clr_o == ($past(m) inside {4'h1, 4'hb}))
    else $error("timer clear in wrong mode");
  pulse_width_a:
    assert property (hit && m inside {4'ha, 4'hb}
      |-> ##2 cmp_out_o ##[1:8] !cmp_out_o)
    else $error("pulse shape wrong");
  zero_ctrl_a:
    assert property (wr && adr_i == ccu_pkg::ADR_CTRL && dat_i[7:0] == 8'h00
      |-> ##2 !cmp_out_o) else $error("latch not forced low");
  open_drain_a:
    assert property (c_s[7] && c_s[6] && $past(c_s[6], 2) |-> !pin_o)
    else $error("open drain drove high");
endmodule // ccu_properties
bind ccu_top ccu_properties i_ccu_properties (.clk_i, .rst_i, .ce_i,
  .cyc_i, .stb_i, .we_i, .ack_o, .adr_i, .sel_i, .dat_i, .timer_i,
  .timer_tick_i, .timer_clr_o, .pin_o, .cmp_out_o, .irq_flag_o);
`default_nettype wire

// File: test/ccu_tmr_model.sv
// free-running timer standing beside the unit
`timescale 1ns/10ps
`default_nettype none
module ccu_tmr_model #(
  parameter int DIV = 4
) (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic run_i,
  output logic [15:0] cnt_o,
  output logic tick_o
);
  logic [7:0] div_r;
  // divided tick, never the raw clock, so pin events are seen
  assign tick_o = run_i && div_r == 8'(DIV - 1);
  always_ff @(posedge clk_i) begin
    if (clr_i || tick_o) div_r <= 8'h00;
    else if (run_i) div_r <= div_r + 8'h01;
  end
  // a stalled count holds, as in sleep; one count serves all units
  always_ff @(posedge clk_i) begin
    if (clr_i) cnt_o <= 16'h0000;
    else if (tick_o) cnt_o <= cnt_o + 16'h0001;
  end
endmodule // ccu_tmr_model
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_i = 1, ce = 1, cyc = 0, stb = 0, we = 0;
  logic run = 0, tz = 0, ext = 1, pw, ack, clr, pin, oe, cmp, flag, tick;
  logic [3:0] adr = 4'h0, sel = 4'h1, src = 4'h0;
  logic [31:0] dat = 32'h0, dat_o, rd;
  logic [15:0] tmr, v;
  logic [3:0] md [5] = '{4'h3, 4'h4, 4'h6, 4'h7, 4'h5};
  int cn [5] = '{1, 1, 4, 16, 1};
  logic [7:0] mt [6] = '{8'h88, 8'h89, 8'h82, 8'h81, 8'h8a, 8'h8b};
  logic [5:0] e1 = 6'h3d, e2 = 6'h0d, ec = 6'h28;
  int err_total = 0, num_checks = 0, cyc_n = 0;
  ccu_top i_ccu_top (.clk_i, .rst_i, .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o, .ack_o(ack),
    .timer_i(tmr), .timer_tick_i(tick), .timer_clr_o(clr),
    .cap_src_i({src[3:1], pw}), .pin_o(pin), .pin_oe_o(oe),
    .cmp_out_o(cmp), .irq_flag_o(flag));
  ccu_tmr_model i_ccu_tmr_model (.clk_i, .clr_i(rst_i | tz | clr),
    .run_i(run), .cnt_o(tmr), .tick_o(tick));
  // the capture detector sees the wire, driven or not
  assign pw = oe ? pin : ext;
  initial forever #2 clk_i = ~clk_i;
  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 6000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] a, e);
    num_checks++;
    if (a !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0; stb <= 0;
  endtask
  task automatic rv;
    bus(0, ccu_pkg::ADR_VAL_LO, 8'h0); v[7:0] = rd[7:0];
    bus(0, ccu_pkg::ADR_VAL_HI, 8'h0); v[15:8] = rd[7:0];
  endtask
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk_i) ext <= 0;
      repeat (6) @(posedge clk_i);
      ext <= 1;
      repeat (6) @(posedge clk_i);
    end
  endtask
  task automatic tmove;
    run <= 1; repeat (5) @(posedge clk_i); run <= 0;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    bus(1, 4'h1, 8'hff);
    for (int a = 0; a < 16; a++) begin
      bus(0, 4'(a), 8'h0); chk(rd[15:0], 16'h0);
    end
    for (int i = 0; i < 5; i++) begin
      tmove();
      bus(1, ccu_pkg::ADR_CTRL, 8'h0);
      bus(1, ccu_pkg::ADR_CTRL, {4'h8, md[i]});
      edges(cn[i] - 1);
      @(negedge clk_i) chk(flag, 0);
      edges(1);
      @(negedge clk_i) chk(flag, 1);
      rv(); chk(v, tmr);
    end
    tmove(); edges(1); tmove(); edges(1);
    rv(); chk(v, tmr);
    chk(flag, 1);
    bus(1, ccu_pkg::ADR_CTRL, 8'h86); edges(2);
    bus(1, ccu_pkg::ADR_CTRL, 8'h80); bus(1, ccu_pkg::ADR_CTRL, 8'h86);
    edges(3); @(negedge clk_i) chk(flag, 0);
    edges(1); @(negedge clk_i) chk(flag, 1);
    bus(1, ccu_pkg::ADR_CAPSEL, 8'h1); bus(1, ccu_pkg::ADR_CTRL, 8'h85);
    edges(1); @(negedge clk_i) chk(flag, 0);
    @(posedge clk_i) src <= 4'h2;
    repeat (6) @(negedge clk_i);
    chk(flag, 1);
    bus(1, ccu_pkg::ADR_VAL_LO, 8'h10); bus(1, ccu_pkg::ADR_VAL_HI, 8'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1, ccu_pkg::ADR_CTRL, 8'h0);
      repeat (2) @(negedge clk_i);
      chk(cmp, 0);
      @(posedge clk_i) tz <= 1;
      @(posedge clk_i) tz <= 0;
      bus(1, ccu_pkg::ADR_CTRL, mt[i]);
      run <= 1;
      do @(negedge clk_i); while (flag !== 1'b1);
      @(negedge clk_i) chk(cmp, e1[i]);
      repeat (8) @(negedge clk_i);
      chk(cmp, e2[i]);
      chk(tmr < 16'h10, ec[i]);
      run <= 0;
    end
    bus(1, ccu_pkg::ADR_CTRL, 8'h0); bus(1, ccu_pkg::ADR_CTRL, 8'hc9);
    repeat (3) @(negedge clk_i);
    chk({oe, pin}, 2'h2);
    bus(1, ccu_pkg::ADR_CTRL, 8'h85);
    @(posedge clk_i) ce <= 0;
    src <= 4'h0;
    repeat (6) @(posedge clk_i);
    src <= 4'h2;
    repeat (6) @(posedge clk_i);
    ce <= 1;
    repeat (6) @(negedge clk_i);
    chk(flag, 0);
    test_done();
  end
endmodule // tb
`default_nettype wire
